// ===== hdl/wrt_map.svh
// Register indices, field positions, reset values and counts of the watchdog
`ifndef WRT_MAP_SVH
`define WRT_MAP_SVH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define WRT_IDX_INT_EN 8'h23
`define WRT_IDX_INT_FLAG 8'h26
`define WRT_IDX_PWR_STAT 8'h2c
`define WRT_IDX_WDT_CTRL 8'h3a
`define WRT_IDX_WDT_CLEAR 8'h3b

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define WRT_GLOBAL_IE_BIT 7
`define WRT_WDT_IE_BIT 4
`define WRT_WDT_IF_BIT 4
`define WRT_TIMEOUT_BIT 5
`define WRT_START_BIT 3
`define WRT_SEL_MSB 2
`define WRT_CLEAR_BIT 0

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define WRT_INT_EN_RST 8'h00
`define WRT_SEL_RST 3'h0

// ------------------------------------------------------------------
// Division counts and vector
// ------------------------------------------------------------------
`define WRT_LONG_PRESCALE 15'h0100
`define WRT_BASE_DIV 15'h0040
`define WRT_IRQ_VECTOR 16'h0004

`endif

// ===== hdl/wrt_pkg.sv
// Types shared by the watchdog and its bench
package wrt_pkg;

  typedef enum logic [1:0] {
    WRT_MODE_RUN = 2'h0,
    WRT_MODE_IDLE = 2'h1,
    WRT_MODE_SLEEP = 2'h3
  } wrt_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wrt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wrt_apb_rsp_t;

endpackage

// ===== hdl/wrt_watchdog.sv
// Watchdog timer with run-mode reset, idle-mode wake interrupt and APB registers
//
// How it works
// [RQ1] Run-mode overflow pulses the chip reset
// [RQ2] Software clear zeroes count in run mode
// [RQ3] Sleep mode: no counting, reset or interrupt
// [RQ4] Idle-mode overflow wakes chip, no reset
// [RQ5] Clear requests ignored while idle
// [RQ6] Counts oscillator ticks in run and idle
// [RQ7] Enabled idle overflow flags and vectors interrupt
// [RQ8] Either enable low: no interrupt taken
// [RQ9] Software starts watchdog while in run mode
// [RQ10] Start bit cannot be cleared once set
// [RQ11] Overflow forces period select to zero
// [RQ12] Timeout flag set on run-mode overflow
// [RQ13] Select picks long or short division
// [RQ14] Start at bit 3, select bits 2..0
// [RQ15] Count restarts from zero after overflow/clear
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "wrt_map.svh"

module wrt_watchdog #(
  parameter int LPO_DIV = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Power mode from the power manager
  input wire wrt_pkg::wrt_mode_t mode_i,
  // APB slave
  input wire wrt_pkg::wrt_apb_req_t apb_req_i,
  output wrt_pkg::wrt_apb_rsp_t apb_rsp_o,
  // Watchdog actions
  output logic chip_reset_o,
  output logic wake_o,
  output logic irq_o,
  output logic [15:0] irq_vector_o
);
  import wrt_pkg::*;

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [7:0] int_en_reg;
  logic flag_reg;
  logic timeout_reg;
  logic start_reg;
  logic [2:0] sel_reg;
  logic [13:0] count_reg;
  logic [7:0] div_reg;
  logic tick_reg;
  logic chip_reset_reg;
  logic wake_reg;
  logic irq_reg;
  logic [15:0] vector_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic setup;
  logic wr_acc;
  logic hit;
  logic [7:0] idx;
  logic [7:0] rd_byte;
  logic active;
  logic [14:0] limit;
  logic ovf;
  logic ovf_run;
  logic ovf_idle;
  logic sw_clear;

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // One wait-free access: pready rises at the edge that ends setup
  assign idx = apb_req_i.paddr[9:2];
  assign setup = apb_req_i.psel && !apb_req_i.penable;
  assign hit = (apb_req_i.paddr[11:10] == 2'h0) && (apb_req_i.paddr[1:0] == 2'h0) &&
               ((idx == `WRT_IDX_INT_EN) || (idx == `WRT_IDX_INT_FLAG) ||
                (idx == `WRT_IDX_PWR_STAT) || (idx == `WRT_IDX_WDT_CTRL) ||
                (idx == `WRT_IDX_WDT_CLEAR));
  assign wr_acc = apb_req_i.psel && apb_req_i.penable && pready_reg && apb_req_i.pwrite &&
                  !pslverr_reg;

  always_comb begin
    rd_byte = 8'h00;
    if (idx == `WRT_IDX_INT_EN) begin
      rd_byte = int_en_reg;
    end else if (idx == `WRT_IDX_INT_FLAG) begin
      rd_byte[`WRT_WDT_IF_BIT] = flag_reg;
    end else if (idx == `WRT_IDX_PWR_STAT) begin
      rd_byte[`WRT_TIMEOUT_BIT] = timeout_reg;
    end else if (idx == `WRT_IDX_WDT_CTRL) begin
      rd_byte[`WRT_START_BIT] = start_reg; // RQ14
      rd_byte[`WRT_SEL_MSB:0] = sel_reg; // RQ14
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !hit;
      if (setup && hit && !apb_req_i.pwrite) begin
        prdata_reg <= {24'h00_0000, rd_byte};
      end else if (setup) begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------------
  // Count clock divider
  // ------------------------------------------------------------------
  // Oscillator runs free, so the tick stays even while the watchdog sleeps
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else if (div_reg == 8'(LPO_DIV - 1)) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Watchdog counter
  // ------------------------------------------------------------------
  assign active = start_reg && (mode_i != WRT_MODE_SLEEP); // RQ3 RQ6
  // Long codes add a fixed prescale in front of the base division
  assign limit = sel_reg[2] ? (`WRT_BASE_DIV >> sel_reg[1:0]) :
                 15'(`WRT_LONG_PRESCALE * (`WRT_BASE_DIV >> sel_reg[1:0])); // RQ13
  // Compare by >= so a shorter period chosen mid-count still overflows
  assign ovf = active && tick_reg && ((15'(count_reg) + 15'h0001) >= limit); // RQ13
  assign ovf_run = ovf && (mode_i == WRT_MODE_RUN);
  assign ovf_idle = ovf && (mode_i == WRT_MODE_IDLE);
  assign sw_clear = wr_acc && (idx == `WRT_IDX_WDT_CLEAR) &&
                    apb_req_i.pwdata[`WRT_CLEAR_BIT] && (mode_i == WRT_MODE_RUN); // RQ2 RQ5

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_reg <= 14'h0000;
    end else if (active) begin
      if (ovf || sw_clear) begin
        count_reg <= 14'h0000; // RQ15 RQ2
      end else if (tick_reg) begin
        count_reg <= count_reg + 14'h0001; // RQ6
      end
    end
  end

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_reg <= 1'b0;
    end else if (wr_acc && (idx == `WRT_IDX_WDT_CTRL) && apb_req_i.pwdata[`WRT_START_BIT]) begin
      start_reg <= 1'b1; // RQ10 RQ14
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_reg <= `WRT_SEL_RST;
    end else if (ovf) begin
      sel_reg <= 3'h0; // RQ11
    end else if (wr_acc && (idx == `WRT_IDX_WDT_CTRL)) begin
      sel_reg <= apb_req_i.pwdata[`WRT_SEL_MSB:0]; // RQ14
    end
  end

  // ------------------------------------------------------------------
  // Status and interrupt registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_en_reg <= `WRT_INT_EN_RST;
    end else if (wr_acc && (idx == `WRT_IDX_INT_EN)) begin
      int_en_reg <= apb_req_i.pwdata[7:0];
    end
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_reg <= 1'b0;
    end else if (ovf_idle) begin
      flag_reg <= 1'b1; // RQ7
    end else if (wr_acc && (idx == `WRT_IDX_INT_FLAG) && apb_req_i.pwdata[`WRT_WDT_IF_BIT]) begin
      flag_reg <= 1'b0;
    end
  end

  // Cleared by the reset input or by writing 0 to its bit, not by chip reset, so it survives the reset it reports
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timeout_reg <= 1'b0;
    end else if (ovf_run) begin
      timeout_reg <= 1'b1; // RQ12
    end else if (wr_acc && (idx == `WRT_IDX_PWR_STAT) &&
                 !apb_req_i.pwdata[`WRT_TIMEOUT_BIT]) begin
      timeout_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Actions
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chip_reset_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      chip_reset_reg <= ovf_run; // RQ1
      wake_reg <= ovf_idle; // RQ4
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_reg <= 1'b0;
      vector_reg <= 16'h0000;
    end else begin
      irq_reg <= flag_reg && int_en_reg[`WRT_WDT_IE_BIT] &&
                 int_en_reg[`WRT_GLOBAL_IE_BIT]; // RQ7 RQ8
      vector_reg <= (flag_reg && int_en_reg[`WRT_WDT_IE_BIT] && int_en_reg[`WRT_GLOBAL_IE_BIT]) ?
                    `WRT_IRQ_VECTOR : 16'h0000; // RQ7
    end
  end

  assign apb_rsp_o.prdata = prdata_reg;
  assign apb_rsp_o.pready = pready_reg;
  assign apb_rsp_o.pslverr = pslverr_reg;
  assign chip_reset_o = chip_reset_reg;
  assign wake_o = wake_reg;
  assign irq_o = irq_reg;
  assign irq_vector_o = vector_reg;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_run_ovf;
    ovf && (mode_i == WRT_MODE_RUN);
  endsequence

  sequence s_idle_ovf;
    ovf && (mode_i == WRT_MODE_IDLE);
  endsequence

  sequence s_run_pulse;
    chip_reset_o && !wake_o ##1 !chip_reset_o;
  endsequence

  sequence s_apb_setup;
    apb_req_i.psel && !apb_req_i.penable;
  endsequence

  sequence s_apb_answer;
    apb_rsp_o.pready ##1 !apb_rsp_o.pready;
  endsequence

  // Periods written out per code, apart from the shifted form that the counter uses
  function automatic logic [14:0] wrt_doc_limit(input logic [2:0] code);
    logic [14:0] lim_val;
    lim_val = 15'h0000;
    unique case (code)
      3'h0: lim_val = 15'h4000;
      3'h1: lim_val = 15'h2000;
      3'h2: lim_val = 15'h1000;
      3'h3: lim_val = 15'h0800;
      3'h4: lim_val = 15'h0040;
      3'h5: lim_val = 15'h0020;
      3'h6: lim_val = 15'h0010;
      3'h7: lim_val = 15'h0008;
    endcase
    return lim_val;
  endfunction

  // Cycles since the last count tick; a slow or stuck divider shows here first
  logic [7:0] gap_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_reg <= 8'h00;
    end else if (tick_reg) begin
      gap_reg <= 8'h01;
    end else begin
      gap_reg <= gap_reg + 8'h01;
    end
  end

  // Bus answer
  apb_answer_a: assert property (s_apb_setup |=> s_apb_answer)
    else $error("access cycle did not answer once");
  apb_error_a: assert property (apb_req_i.psel && !apb_req_i.penable && !hit |=>
      apb_rsp_o.pslverr && (apb_rsp_o.prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  // Run mode
  run_reset_a: assert property (s_run_ovf |=> s_run_pulse) // RQ1
    else $error("run overflow did not pulse chip reset");
  reset_pulse_a: assert property (chip_reset_o |=> !chip_reset_o) // RQ1
    else $error("chip reset longer than one cycle");
  run_clear_a: assert property (sw_clear && active && !ovf |=> count_reg == 14'h0000) // RQ2
    else $error("software clear did not zero the count");

  // Sleep mode
  sleep_hold_a: assert property ((mode_i == WRT_MODE_SLEEP) |=> // RQ3
      $stable(count_reg) && !chip_reset_o && !wake_o)
    else $error("watchdog active in sleep");
  sleep_quiet_a: assert property ((mode_i == WRT_MODE_SLEEP) |-> !ovf) // RQ3
    else $error("overflow while asleep");

  // Idle mode
  idle_wake_a: assert property (s_idle_ovf |=> wake_o && !chip_reset_o ##1 // RQ4 RQ7
      irq_o == $past(int_en_reg[7] && int_en_reg[4]))
    else $error("idle overflow did not wake");
  wake_pulse_a: assert property (wake_o |=> !wake_o) // RQ4
    else $error("wake longer than one cycle");
  idle_noclear_a: assert property ((mode_i == WRT_MODE_IDLE) && active && tick_reg && !ovf |=> // RQ5 RQ6
      count_reg == $past(count_reg) + 14'h0001)
    else $error("idle count did not advance");
  idle_clear_a: assert property ((mode_i == WRT_MODE_IDLE) && wr_acc && // RQ5
      (idx == `WRT_IDX_WDT_CLEAR) && active && tick_reg && !ovf |=> count_reg != 14'h0000)
    else $error("idle clear zeroed the count");
  tick_ratio_a: assert property (tick_reg |-> gap_reg == 8'(LPO_DIV)) // RQ6
    else $error("count tick off the divider ratio");

  // Interrupt
  idle_flag_a: assert property (s_idle_ovf |=> flag_reg) // RQ7
    else $error("idle overflow did not set the flag");
  irq_raise_a: assert property (flag_reg && int_en_reg[`WRT_WDT_IE_BIT] && // RQ7
      int_en_reg[`WRT_GLOBAL_IE_BIT] |=> irq_o)
    else $error("enabled flag did not raise the interrupt");
  vector_match_a: assert property (irq_o |-> irq_vector_o == `WRT_IRQ_VECTOR) // RQ7
    else $error("vector missing while interrupt is up");
  vector_idle_a: assert property (!irq_o |-> irq_vector_o == 16'h0000) // RQ8
    else $error("vector shown without interrupt");
  irq_gate_a: assert property (irq_o |-> $past(flag_reg) && // RQ8
      $past(int_en_reg[`WRT_WDT_IE_BIT]) && $past(int_en_reg[`WRT_GLOBAL_IE_BIT]))
    else $error("interrupt without both enables");

  // Control and status
  start_sticky_a: assert property (start_reg |=> start_reg) // RQ10
    else $error("start bit was cleared");
  start_set_a: assert property (wr_acc && (idx == `WRT_IDX_WDT_CTRL) && // RQ10 RQ14
      apb_req_i.pwdata[`WRT_START_BIT] |=> start_reg)
    else $error("start write did not set the bit");
  sel_write_a: assert property (wr_acc && (idx == `WRT_IDX_WDT_CTRL) && !ovf |=> // RQ14
      sel_reg == $past(apb_req_i.pwdata[2:0]))
    else $error("select write lost");
  sel_zero_a: assert property (ovf |=> sel_reg == 3'h0 && count_reg == 14'h0000) // RQ11 RQ15
    else $error("overflow did not zero select and count");
  timeout_set_a: assert property (s_run_ovf |=> timeout_reg [*2]) // RQ12
    else $error("timeout flag not held after run overflow");
  timeout_clr_a: assert property (wr_acc && (idx == `WRT_IDX_PWR_STAT) && // RQ12
      !apb_req_i.pwdata[`WRT_TIMEOUT_BIT] && !ovf_run |=> !timeout_reg)
    else $error("timeout flag not cleared by write");

  // Periods
  limit_reach_a: assert property (ovf |-> // RQ13
      tick_reg && (15'(count_reg) + 15'h0001) >= wrt_doc_limit(sel_reg))
    else $error("overflow before the selected division");
  exact_period_a: assert property (active && tick_reg && // RQ13
      (15'(count_reg) + 15'h0001) == wrt_doc_limit(sel_reg) |-> ovf)
    else $error("no overflow at the selected division");

endmodule

// ===== tb/wrt_watchdog_tb.sv
// Self-checking bench for the watchdog: registers, periods, run, idle and sleep behaviour
`timescale 1ns/10ps
`include "wrt_map.svh"

module wrt_watchdog_tb;
  import wrt_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam logic [11:0] A_EN = {2'b00, `WRT_IDX_INT_EN, 2'b00};
  localparam logic [11:0] A_FLAG = {2'b00, `WRT_IDX_INT_FLAG, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, `WRT_IDX_PWR_STAT, 2'b00};
  localparam logic [11:0] A_CTRL = {2'b00, `WRT_IDX_WDT_CTRL, 2'b00};
  localparam logic [11:0] A_CLR = {2'b00, `WRT_IDX_WDT_CLEAR, 2'b00};
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  wrt_mode_t mode_i = WRT_MODE_RUN;
  wrt_apb_req_t req = '0;
  wrt_apb_rsp_t rsp;
  logic chip_reset_o;
  logic wake_o;
  logic irq_o;
  logic [15:0] irq_vector_o;
  logic [7:0] r;
  logic e;
  int error_cnt = 0;
  int check_count = 0;
  int rst_cnt = 0;
  int wake_cnt = 0;
  int base;
  int n;
  int q;
  int k;

  // Tick every clock so measured periods carry no divider phase
  wrt_watchdog #(.LPO_DIV(1)) wrt_watchdog_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .mode_i(mode_i), .apb_req_i(req), .apb_rsp_o(rsp), .chip_reset_o(chip_reset_o),
    .wake_o(wake_o), .irq_o(irq_o), .irq_vector_o(irq_vector_o));

  always #12.5 clk_i = ~clk_i;

  // Pulses last one cycle, so the falling edge sees each exactly once
  always @(negedge clk_i) begin
    if (chip_reset_o === 1'b1) rst_cnt <= rst_cnt + 1;
    if (wake_o === 1'b1) wake_cnt <= wake_cnt + 1;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic int lim(input int s);
    return s[2] ? (64 >> s[1:0]) : 256 * (64 >> s[1:0]);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask

  // Entered just after a rising edge; ready and the answer are taken at a rising edge only,
  // then an idle cycle follows so psel is never set twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int t;
    t = 0;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h0, d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_i);
      t++;
    end while (rsp.pready !== 1'b1 && t < 50);
    if (rsp.pready !== 1'b1) chk(32'h0, 32'h1, "no ready");
    r = rsp.prdata[7:0];
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x, input string m);
    apb(1'b0, a, 8'h00);
    chk({24'h0, r}, {24'h0, x}, m);
  endtask

  task automatic wait_rst(output int c);
    int s;
    s = rst_cnt;
    c = 0;
    while (rst_cnt == s && c < 20000) begin
      @(posedge clk_i);
      c++;
    end
    chk(rst_cnt, s + 1, "no watchdog reset");
  endtask

  task automatic results();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    rd(A_EN, 8'h00, "enable reset");
    rd(A_FLAG, 8'h00, "flag reset");
    rd(A_STAT, 8'h00, "status reset");
    rd(A_CTRL, 8'h00, "control reset");
    apb(1'b0, 12'h004, 8'h00);
    chk({31'h0, e}, 32'h1, "unmapped access");
    wr(A_CTRL, 8'h07);
    repeat (20) @(posedge clk_i);
    rd(A_CTRL, 8'h07, "select alone");
    chk(rst_cnt, 0, "stopped watchdog fired");
    wr(A_CTRL, 8'h08);
    for (k = 7; k >= 0; k--) begin
      wr(A_CLR, 8'h01);
      wr(A_CTRL, 8'h08 | k[7:0]);
      wait_rst(n);
      if (k == 7) base = n;
      chk(n - base, lim(k) - 8, "overflow period");
      rd(A_CTRL, 8'h08, "select forced to zero");
      rd(A_STAT, 8'h20, "timeout flag");
      wr(A_STAT, 8'h00);
      rd(A_STAT, 8'h00, "timeout flag cleared");
    end
    wr(A_CTRL, 8'h00);
    rd(A_CTRL, 8'h08, "start stays set");
    wr(A_CLR, 8'h01);
    wr(A_CTRL, 8'h0f);
    n = rst_cnt;
    repeat (10) wr(A_CLR, 8'h01);
    chk(rst_cnt, n, "refreshed watchdog fired");
    wait_rst(n);
    q = rst_cnt;
    wr(A_STAT, 8'h00);
    for (k = 0; k < 4; k++) begin
      wr(A_EN, {k[1], 2'b00, k[0], 4'h0});
      mode_i <= WRT_MODE_RUN;
      wr(A_CLR, 8'h01);
      mode_i <= WRT_MODE_IDLE;
      n = wake_cnt;
      wr(A_CTRL, 8'h0f);
      repeat (4) wr(A_CLR, 8'h01);
      chk(wake_cnt, n + 1, "idle wake");
      @(negedge clk_i);
      chk({31'h0, irq_o}, (k == 3) ? 32'h1 : 32'h0, "irq level");
      chk({16'h0, irq_vector_o}, (k == 3) ? {16'h0, `WRT_IRQ_VECTOR} : 32'h0, "vector");
      @(posedge clk_i);
      rd(A_FLAG, 8'h10, "irq flag");
      rd(A_CTRL, 8'h08, "select forced in idle");
      wr(A_FLAG, 8'h10);
      rd(A_FLAG, 8'h00, "irq flag cleared");
      @(negedge clk_i);
      chk({31'h0, irq_o}, 32'h0, "irq after clear");
      @(posedge clk_i);
    end
    chk(rst_cnt, q, "idle reset");
    rd(A_STAT, 8'h00, "no timeout in idle");
    mode_i <= WRT_MODE_RUN;
    wr(A_CLR, 8'h01);
    mode_i <= WRT_MODE_SLEEP;
    wr(A_CTRL, 8'h0f);
    n = rst_cnt + wake_cnt;
    repeat (40) @(posedge clk_i);
    chk(rst_cnt + wake_cnt, n, "sleep activity");
    rd(A_CTRL, 8'h0f, "sleep keeps select");
    mode_i <= WRT_MODE_RUN;
    wait_rst(n);
    results();
  end

  // Whole run is about 31000 cycles
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    results();
  end
endmodule
